// ---- core/pcg_top.sv ----
// peripheral clock gating bank with an AHB-Lite register slave
module pcg_top
   import pcg_pkg::*;
#(
   parameter logic [15:0] PRESENT_TIMER_SERIAL       = 16'hFFFF,
   parameter logic [15:0] PRESENT_CAPTURE_COMPARE    = 16'hFFFF,
   parameter logic [15:0] PRESENT_CRC_UART_ENCODER   = 16'hFFFF,
   parameter logic [15:0] PRESENT_REFERENCE_CLOCK    = 16'hFFFF,
   parameter logic [15:0] PRESENT_DMA_SPI            = 16'hFFFF,
   parameter logic [15:0] PRESENT_COMPARATOR_TRIGGER = 16'hFFFF,
   parameter logic [15:0] PRESENT_ANALOG_SENSOR      = 16'hFFFF
)
(
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output      logic        hreadyout,
   output      logic [31:0] hrdata,
   output      logic        hresp,
   output      logic [15:0] run_timer_serial,
   output      logic [15:0] run_capture_compare,
   output      logic [15:0] run_crc_uart_encoder,
   output      logic [15:0] run_reference_clock,
   output      logic [15:0] run_dma_spi,
   output      logic [15:0] run_comparator_trigger,
   output      logic [15:0] run_analog_sensor,
   output      logic [15:0] gclk_timer_serial,
   output      logic [15:0] gclk_capture_compare,
   output      logic [15:0] gclk_crc_uart_encoder,
   output      logic [15:0] gclk_reference_clock,
   output      logic [15:0] gclk_dma_spi,
   output      logic [15:0] gclk_comparator_trigger,
   output      logic [15:0] gclk_analog_sensor
);

   // ==========================================================
   // bank tables
   localparam logic [15:0] BANK_MASK [PCG_BANKS] = '{
      MASK_TIMER_SERIAL, MASK_CAPTURE_COMPARE, MASK_CRC_UART_ENCODER,
      MASK_REFERENCE_CLOCK, MASK_DMA_SPI, MASK_COMPARATOR_TRIGGER,
      MASK_ANALOG_SENSOR};
   localparam logic [7:0]  BANK_OFS [PCG_BANKS] = '{
      OFS_TIMER_SERIAL, OFS_CAPTURE_COMPARE, OFS_CRC_UART_ENCODER,
      OFS_REFERENCE_CLOCK, OFS_DMA_SPI, OFS_COMPARATOR_TRIGGER,
      OFS_ANALOG_SENSOR};

   logic [15:0] present   [PCG_BANKS];
   logic [15:0] gate_bits [PCG_BANKS];
   logic [15:0] run_w     [PCG_BANKS];
   logic [15:0] gclk_w    [PCG_BANKS];
   logic [PCG_BANKS-1:0] bank_wr;

   assign present[BANK_TIMER_SERIAL]       = PRESENT_TIMER_SERIAL;
   assign present[BANK_CAPTURE_COMPARE]    = PRESENT_CAPTURE_COMPARE;
   assign present[BANK_CRC_UART_ENCODER]   = PRESENT_CRC_UART_ENCODER;
   assign present[BANK_REFERENCE_CLOCK]    = PRESENT_REFERENCE_CLOCK;
   assign present[BANK_DMA_SPI]            = PRESENT_DMA_SPI;
   assign present[BANK_COMPARATOR_TRIGGER] = PRESENT_COMPARATOR_TRIGGER;
   assign present[BANK_ANALOG_SENSOR]      = PRESENT_ANALOG_SENSOR;

   // ==========================================================
   // address phase capture
   logic       addr_valid;
   logic       wr_pending;
   logic [7:0] wr_addr;
   logic [7:0] cur_addr;

   assign addr_valid = hsel & hready & (htrans == HTRANS_NONSEQ | htrans == HTRANS_SEQ);
   assign cur_addr   = {haddr[PCG_ADDR_BITS-1:2], 2'h0};

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pending <= 1'b0;
      end else if (hready) begin
         wr_pending <= addr_valid & hwrite;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_addr <= 8'h00;
      end else if (addr_valid) begin
         wr_addr <= cur_addr;
      end
   end

   // upper address bits must also be zero, else the access is unmapped
   logic        hi_clear;
   logic        wr_hi_clear;
   assign hi_clear = (haddr[31:PCG_ADDR_BITS] == 24'h000000);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_hi_clear <= 1'b0;
      end else if (addr_valid) begin
         wr_hi_clear <= hi_clear;
      end
   end

   // ==========================================================
   // write strobes, one per bank, in the data phase
   genvar bi;
   generate
      for (bi = 0; bi < PCG_BANKS; bi++) begin : g_bank
         assign bank_wr[bi] = wr_pending & wr_hi_clear & (wr_addr == BANK_OFS[bi]);

         pcg_gate_bank #(
            .IMPL_MASK (BANK_MASK[bi])
         ) u_bank (
            .hclk      (hclk),
            .hresetn   (hresetn),
            .wr_en     (bank_wr[bi]),
            .wr_data   (hwdata[15:0]),
            .present   (present[bi]),
            .gate_bits (gate_bits[bi]),
            .run       (run_w[bi]),
            .gclk      (gclk_w[bi])
         );
      end
   endgenerate

   // ==========================================================
   // named outputs
   // run enables and gated clocks of all seven banks
   assign run_dma_spi             = run_w[BANK_DMA_SPI];
   assign gclk_dma_spi            = gclk_w[BANK_DMA_SPI];
   assign run_comparator_trigger  = run_w[BANK_COMPARATOR_TRIGGER];
   assign gclk_comparator_trigger = gclk_w[BANK_COMPARATOR_TRIGGER];
   assign run_analog_sensor       = run_w[BANK_ANALOG_SENSOR];
   assign gclk_analog_sensor      = gclk_w[BANK_ANALOG_SENSOR];
   assign run_timer_serial        = run_w[BANK_TIMER_SERIAL];
   assign run_capture_compare     = run_w[BANK_CAPTURE_COMPARE];
   assign run_crc_uart_encoder    = run_w[BANK_CRC_UART_ENCODER];
   assign run_reference_clock     = run_w[BANK_REFERENCE_CLOCK];
   assign gclk_timer_serial       = gclk_w[BANK_TIMER_SERIAL];
   assign gclk_capture_compare    = gclk_w[BANK_CAPTURE_COMPARE];
   assign gclk_crc_uart_encoder   = gclk_w[BANK_CRC_UART_ENCODER];
   assign gclk_reference_clock    = gclk_w[BANK_REFERENCE_CLOCK];

   // ==========================================================
   // per field views used by the status word
   logic       dma_ch_any_off;
   logic       serial_if3_off;
   logic       comparator_any_off;
   logic       trigger_pattern_gen_off;
   logic       amplifiers_off;
   logic       nibble_link_any_off;
   logic       deadman_timer_off;
   logic       logic_cell_any_off;
   logic       current_source_off;

   assign dma_ch_any_off = |gate_bits[BANK_DMA_SPI][POS_DMA_CH3_OFF:POS_DMA_CH0_OFF];
   assign serial_if3_off = gate_bits[BANK_DMA_SPI][POS_SERIAL_IF3_OFF];
   assign comparator_any_off =
      |gate_bits[BANK_COMPARATOR_TRIGGER][POS_COMPARATOR3_OFF:POS_COMPARATOR1_OFF];
   assign trigger_pattern_gen_off = gate_bits[BANK_COMPARATOR_TRIGGER][POS_TRIGGER_PATTERN_GEN_OFF];
   assign amplifiers_off = gate_bits[BANK_ANALOG_SENSOR][POS_AMPLIFIERS_OFF];
   assign nibble_link_any_off =
      |gate_bits[BANK_ANALOG_SENSOR][POS_NIBBLE_LINK2_OFF:POS_NIBBLE_LINK1_OFF];
   assign deadman_timer_off = gate_bits[BANK_ANALOG_SENSOR][POS_DEADMAN_TIMER_OFF];
   assign logic_cell_any_off =
      |gate_bits[BANK_ANALOG_SENSOR][POS_LOGIC_CELL4_OFF:POS_LOGIC_CELL1_OFF];
   assign current_source_off = gate_bits[BANK_ANALOG_SENSOR][POS_CURRENT_SOURCE_OFF];

   // ==========================================================
   // status word: which banks hold a stopped module, plus summary fields
   logic [15:0] gate_status;
   logic [PCG_BANKS-1:0] bank_stopped;

   generate
      for (bi = 0; bi < PCG_BANKS; bi++) begin : g_stat
         assign bank_stopped[bi] = |(~run_w[bi] & BANK_MASK[bi]);
      end
   endgenerate

   assign gate_status = {bank_stopped, dma_ch_any_off, serial_if3_off, comparator_any_off,
                         trigger_pattern_gen_off, amplifiers_off, nibble_link_any_off,
                         deadman_timer_off, logic_cell_any_off, current_source_off};

   // ==========================================================
   // read mux
   // a write in its data phase is merged, so back to back write then
   // read of the same word returns the new value
   logic [15:0] next_rdata;
   logic [15:0] bank_view;

   always_comb begin
      next_rdata = 16'h0000;
      for (int i = 0; i < PCG_BANKS; i++) begin
         bank_view = gate_bits[i];
         if (bank_wr[i]) begin
            bank_view = hwdata[15:0] & BANK_MASK[i];
         end
         if (cur_addr == BANK_OFS[i]) begin
            next_rdata = bank_view & BANK_MASK[i];
         end
      end
      if (cur_addr == OFS_GATE_STATUS) begin
         next_rdata = gate_status;
      end
      if (!hi_clear) begin
         next_rdata = 16'h0000;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h00000000;
      end else if (addr_valid & !hwrite) begin
         hrdata <= {16'h0000, next_rdata};
      end
   end

   // ==========================================================
   // zero wait state slave, always OKAY
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b1;
         hresp     <= HRESP_OKAY;
      end else begin
         hreadyout <= 1'b1;
         hresp     <= HRESP_OKAY;
      end
   end

endmodule : pcg_top

// ---- core/pcg_pkg.sv ----
// constants for the peripheral clock gating bank
package pcg_pkg;

   // ==========================================================
   // bank geometry
   localparam int          PCG_BANKS      = 7;
   localparam int          PCG_WIDTH      = 16;
   localparam int          PCG_ADDR_BITS  = 8;

   // ==========================================================
   // register byte offsets
   localparam logic [7:0]  OFS_TIMER_SERIAL       = 8'h00;
   localparam logic [7:0]  OFS_CAPTURE_COMPARE    = 8'h04;
   localparam logic [7:0]  OFS_CRC_UART_ENCODER   = 8'h08;
   localparam logic [7:0]  OFS_REFERENCE_CLOCK    = 8'h0C;
   localparam logic [7:0]  OFS_HOLE_FIVE          = 8'h10;
   localparam logic [7:0]  OFS_DMA_SPI            = 8'h14;
   localparam logic [7:0]  OFS_COMPARATOR_TRIGGER = 8'h18;
   localparam logic [7:0]  OFS_ANALOG_SENSOR      = 8'h1C;
   localparam logic [7:0]  OFS_GATE_STATUS        = 8'h20;

   // bank index, in register order
   localparam int          BANK_TIMER_SERIAL       = 0;
   localparam int          BANK_CAPTURE_COMPARE    = 1;
   localparam int          BANK_CRC_UART_ENCODER   = 2;
   localparam int          BANK_REFERENCE_CLOCK    = 3;
   localparam int          BANK_DMA_SPI            = 4;
   localparam int          BANK_COMPARATOR_TRIGGER = 5;
   localparam int          BANK_ANALOG_SENSOR      = 6;

   // ==========================================================
   // implemented bit masks and reset values
   localparam logic [15:0] MASK_TIMER_SERIAL       = 16'h0EF9;
   localparam logic [15:0] MASK_CAPTURE_COMPARE    = 16'h001F;
   localparam logic [15:0] MASK_CRC_UART_ENCODER   = 16'h00AA;
   localparam logic [15:0] MASK_REFERENCE_CLOCK    = 16'h0008;
   localparam logic [15:0] MASK_DMA_SPI            = 16'h0F01;
   localparam logic [15:0] MASK_COMPARATOR_TRIGGER = 16'h0708;
   localparam logic [15:0] MASK_ANALOG_SENSOR      = 16'h393E;
   localparam logic [15:0] GATE_RESET              = 16'h0000;

   // ==========================================================
   // field positions in the last three banks
   localparam int          POS_DMA_CH0_OFF            = 8;
   localparam int          POS_DMA_CH3_OFF            = 11;
   localparam int          POS_SERIAL_IF3_OFF         = 0;
   localparam int          POS_COMPARATOR1_OFF        = 8;
   localparam int          POS_COMPARATOR3_OFF        = 10;
   localparam int          POS_TRIGGER_PATTERN_GEN_OFF = 3;
   localparam int          POS_AMPLIFIERS_OFF         = 13;
   localparam int          POS_NIBBLE_LINK1_OFF       = 11;
   localparam int          POS_NIBBLE_LINK2_OFF       = 12;
   localparam int          POS_DEADMAN_TIMER_OFF      = 8;
   localparam int          POS_LOGIC_CELL1_OFF        = 2;
   localparam int          POS_LOGIC_CELL4_OFF        = 5;
   localparam int          POS_CURRENT_SOURCE_OFF     = 1;

   // ==========================================================
   // timing
   localparam int          HCLK_PERIOD_NS    = 40;
   localparam int          INSTR_CYCLE_NS    = 40;
   localparam int          SWITCH_DELAY_CYC  =
      (INSTR_CYCLE_NS + HCLK_PERIOD_NS - 1) / HCLK_PERIOD_NS;

   // ==========================================================
   // bus encodings
   localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0]  HTRANS_SEQ    = 2'h3;
   localparam logic        HRESP_OKAY    = 1'h0;

endpackage : pcg_pkg

// ---- core/pcg_clk_gate.sv ----
// glitch-free latch based clock gate for one module clock
module pcg_clk_gate
   import pcg_pkg::*;
(
   input  wire logic clk_in,
   input  wire logic enable,
   output      logic clk_out
);

   logic en_latched;

   // ==========================================================
   // enable latch
   // transparent only while clock is low, so a late enable change
   // can never clip a high phase already in flight
   // low-phase latch
   always_latch begin
      if (!clk_in) begin
         en_latched <= enable;
      end
   end

   assign clk_out = clk_in & en_latched;

endmodule : pcg_clk_gate

// ---- core/pcg_gate_bank.sv ----
// one sixteen bit disable register with its run enables and gated clocks
module pcg_gate_bank
   import pcg_pkg::*;
#(
   parameter logic [15:0] IMPL_MASK = 16'h0000
)
(
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        wr_en,
   input  wire logic [15:0] wr_data,
   input  wire logic [15:0] present,
   output      logic [15:0] gate_bits,
   output      logic [15:0] run,
   output      logic [15:0] gclk
);

   // ==========================================================
   // disable bits
   // reset enabled
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         gate_bits <= GATE_RESET;
      end else if (wr_en) begin
         gate_bits <= wr_data & IMPL_MASK;
      end
   end

   // ==========================================================
   // run enables, one clock behind the stored bit
   // one cycle delay
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         run <= GATE_RESET;
      end else begin
         run <= ~gate_bits & present & IMPL_MASK;
      end
   end

   // ==========================================================
   // per bit clock gates
   genvar gi;
   generate
      for (gi = 0; gi < PCG_WIDTH; gi++) begin : g_bit
         if (IMPL_MASK[gi]) begin : g_impl
            pcg_clk_gate u_gate (
               .clk_in  (hclk),
               .enable  (run[gi]),
               .clk_out (gclk[gi])
            );
         end else begin : g_none
            assign gclk[gi] = 1'b0;
         end
      end
   endgenerate

endmodule : pcg_gate_bank

// ---- dv/pcg_top_sva.sv ----
// assertion checker for the clock gating bank ports
module pcg_top_sva
   import pcg_pkg::*;
(
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic        hready,
   input  wire logic [31:0] hwdata,
   input  wire logic [31:0] hrdata,
   input  wire logic [15:0] run_dma_spi,
   input  wire logic [15:0] run_comparator_trigger,
   input  wire logic [15:0] run_analog_sensor,
   input  wire logic [15:0] gclk_analog_sensor
);
   timeunit 1ns;
   timeprecision 1ps;

   // ==========================================================
   // helper logic
   logic       wr_q1;
   logic [7:0] ad_q1;
   logic [1:0] live;

   // live hides the jump of run right after reset release
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_q1 <= 1'b0;
         ad_q1 <= 8'h00;
         live  <= 2'h0;
      end else begin
         wr_q1 <= hsel && hready && htrans[1] && hwrite && haddr[31:8] == 24'h000000;
         ad_q1 <= haddr[7:0];
         if (live != 2'h3) begin
            live <= live + 2'h1;
         end
      end
   end

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   // ==========================================================
   // assertions
   a_upper_read_zero: assert property (hrdata[31:16] == 16'h0000)
      else $error("upper read data not zero");
   a_run_masked: assert property (((run_dma_spi & ~MASK_DMA_SPI) | (run_analog_sensor & ~MASK_ANALOG_SENSOR)
      | (run_comparator_trigger & ~MASK_COMPARATOR_TRIGGER)) == 16'h0000)
      else $error("run set on unimplemented bit");
   a_reset_run: assert property (live == 2'h1 |-> run_dma_spi == MASK_DMA_SPI
      && run_analog_sensor == MASK_ANALOG_SENSOR)
      else $error("modules not running after reset");
   a_switch_delay: assert property (live[1] && ($changed(run_dma_spi) || $changed(run_comparator_trigger)
      || $changed(run_analog_sensor)) |-> $past(wr_q1, 2))
      else $error("run changed without a write two cycles before");
   a_dma_fields: assert property (wr_q1 && ad_q1 == OFS_DMA_SPI
      |-> ##2 run_dma_spi == (~$past(hwdata[15:0], 2) & MASK_DMA_SPI))
      else $error("dma spi run does not follow write");
   a_cmp_fields: assert property (wr_q1 && ad_q1 == OFS_COMPARATOR_TRIGGER
      |-> ##2 run_comparator_trigger == (~$past(hwdata[15:0], 2) & MASK_COMPARATOR_TRIGGER))
      else $error("comparator run does not follow write");
   a_analog_fields: assert property (wr_q1 && ad_q1 == OFS_ANALOG_SENSOR
      |-> ##2 run_analog_sensor == (~$past(hwdata[15:0], 2) & MASK_ANALOG_SENSOR))
      else $error("analog run does not follow write");
   a_gclk_follows: assert property (@(negedge hclk) disable iff (!hresetn)
      gclk_analog_sensor == $past(run_analog_sensor))
      else $error("gated clock does not follow latched run");

   c_dma_write: cover property (wr_q1 && ad_q1 == OFS_DMA_SPI);
   c_analog_write: cover property (wr_q1 && ad_q1 == OFS_ANALOG_SENSOR);
   c_run_change: cover property (live[1] && $changed(run_analog_sensor));
endmodule : pcg_top_sva

bind pcg_top pcg_top_sva u_sva (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
   .hwrite(hwrite), .hready(hready), .hwdata(hwdata), .hrdata(hrdata), .run_dma_spi(run_dma_spi),
   .run_comparator_trigger(run_comparator_trigger), .run_analog_sensor(run_analog_sensor),
   .gclk_analog_sensor(gclk_analog_sensor));

// ---- dv/pcg_top_bench.sv ----
// self-checking bench for the clock gating bank
module pcg_top_bench
   import pcg_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   // ==========================================================
   // signals and model
   logic        hclk, hresetn, hsel, hwrite;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic        hreadyout, hresp;
   wire         hready = hreadyout;
   logic [15:0] run_v [7];
   logic [15:0] gclk_v [7];
   logic [15:0] mdl [7];
   int          errors, n_checks, cycles;
   localparam logic [15:0] MASKS [7] = '{MASK_TIMER_SERIAL, MASK_CAPTURE_COMPARE, MASK_CRC_UART_ENCODER,
      MASK_REFERENCE_CLOCK, MASK_DMA_SPI, MASK_COMPARATOR_TRIGGER, MASK_ANALOG_SENSOR};
   // reference clock bank is built absent to see a stored bit that never runs
   localparam logic [15:0] PRES [7] = '{16'hFFFF, 16'hFFFF, 16'hFFFF, 16'h0000, 16'hFFFF, 16'hFFFF, 16'hFFFF};
   localparam logic [7:0] OFS [7] = '{OFS_TIMER_SERIAL, OFS_CAPTURE_COMPARE, OFS_CRC_UART_ENCODER,
      OFS_REFERENCE_CLOCK, OFS_DMA_SPI, OFS_COMPARATOR_TRIGGER, OFS_ANALOG_SENSOR};

   pcg_top #(.PRESENT_REFERENCE_CLOCK(16'h0000)) u_dut (
      .hclk                    (hclk),
      .hresetn                 (hresetn),
      .hsel                    (hsel),
      .haddr                   (haddr),
      .htrans                  (htrans),
      .hwrite                  (hwrite),
      .hsize                   (hsize),
      .hwdata                  (hwdata),
      .hready                  (hready),
      .hreadyout               (hreadyout),
      .hrdata                  (hrdata),
      .hresp                   (hresp),
      .run_timer_serial        (run_v[0]),
      .run_capture_compare     (run_v[1]),
      .run_crc_uart_encoder    (run_v[2]),
      .run_reference_clock     (run_v[3]),
      .run_dma_spi             (run_v[4]),
      .run_comparator_trigger  (run_v[5]),
      .run_analog_sensor       (run_v[6]),
      .gclk_timer_serial       (gclk_v[0]),
      .gclk_capture_compare    (gclk_v[1]),
      .gclk_crc_uart_encoder   (gclk_v[2]),
      .gclk_reference_clock    (gclk_v[3]),
      .gclk_dma_spi            (gclk_v[4]),
      .gclk_comparator_trigger (gclk_v[5]),
      .gclk_analog_sensor      (gclk_v[6])
   );

   initial begin
      hclk = 1'b0;
      forever #20 hclk = ~hclk;
   end

   // ==========================================================
   // bus and compare tasks
   task automatic summarize;
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : summarize

   task automatic chk_word(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         errors++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk_word

   task automatic chk_run(input string nm, input logic [15:0] exp, input logic [15:0] got);
      n_checks++;
      if (got !== exp) begin
         errors++;
         $display("ERROR %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk_run

   // read data is taken at the edge that closes the data phase
   task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
      haddr  <= a;
      htrans <= HTRANS_NONSEQ;
      hwrite <= w;
      do @(posedge hclk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hready !== 1'b1);
      r = hrdata;
   endtask : xfer

   function automatic logic [15:0] exp_run(input int i);
      return ~mdl[i] & MASKS[i] & PRES[i];
   endfunction : exp_run

   task automatic check_all;
      logic [31:0] r;
      logic [15:0] st;
      st = 16'h0000;
      for (int i = 0; i < 7; i++) begin
         xfer({24'h000000, OFS[i]}, 1'b0, 32'h0, r);
         chk_word("read", {16'h0000, mdl[i]}, r);
         chk_run("run", exp_run(i), run_v[i]);
         // inside the high phase only running modules see a clock
         #1;
         chk_run("gclk", exp_run(i), gclk_v[i]);
         st[9 + i] = |(~exp_run(i) & MASKS[i]);
      end
      st[8:0] = {|mdl[4][POS_DMA_CH3_OFF:POS_DMA_CH0_OFF], mdl[4][POS_SERIAL_IF3_OFF],
         |mdl[5][POS_COMPARATOR3_OFF:POS_COMPARATOR1_OFF], mdl[5][POS_TRIGGER_PATTERN_GEN_OFF],
         mdl[6][POS_AMPLIFIERS_OFF], |mdl[6][POS_NIBBLE_LINK2_OFF:POS_NIBBLE_LINK1_OFF],
         mdl[6][POS_DEADMAN_TIMER_OFF], |mdl[6][POS_LOGIC_CELL4_OFF:POS_LOGIC_CELL1_OFF],
         mdl[6][POS_CURRENT_SOURCE_OFF]};
      xfer({24'h000000, OFS_GATE_STATUS}, 1'b0, 32'h0, r);
      chk_word("status", {16'h0000, st}, r);
      chk_word("resp", {30'h0, 1'b1, HRESP_OKAY}, {30'h0, hreadyout, hresp});
      xfer(32'h0000_0010, 1'b0, 32'h0, r);
      chk_word("hole", 32'h0, r);
      xfer(32'h0000_0114, 1'b0, 32'h0, r);
      chk_word("unmapped", 32'h0, r);
   endtask : check_all

   task automatic wr_bank(input int i, input logic [31:0] d);
      logic [31:0] r;
      logic [15:0] old;
      old = exp_run(i);
      xfer({24'h000000, OFS[i]}, 1'b1, d, r);
      mdl[i] = d[15:0] & MASKS[i];
      #1;
      chk_run("run_before", old, run_v[i]);
      @(posedge hclk);
      #1;
      chk_run("run_after", exp_run(i), run_v[i]);
      // the latch keeps the high phase already running, so the clock lags run
      chk_run("gclk_hold", old, gclk_v[i]);
   endtask : wr_bank

   always @(posedge hclk) begin
      cycles++;
      if (cycles == 8000) begin
         errors++;
         summarize();
      end
   end

   // ==========================================================
   // main sequence
   initial begin
      logic [31:0] r, d;
      int          b;
      hresetn = 1'b0;
      hsel = 1'b1;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      foreach (mdl[i]) mdl[i] = 16'h0000;
      void'($urandom(32'h9C7E2781));
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      check_all();
      for (int i = 0; i < 7; i++) begin
         for (int k = 0; k < 16; k++) begin
            wr_bank(i, 32'hFFFF_0000 | (32'h1 << k));
         end
      end
      for (int i = 0; i < 7; i++) begin
         wr_bank(i, 32'hFFFF_FFFF);
      end
      xfer(32'h0000_0010, 1'b1, 32'hFFFF_FFFF, r);
      xfer(32'h0000_0114, 1'b1, 32'h0, r);
      check_all();
      repeat (60) begin
         b = $urandom_range(6, 0);
         d = $urandom();
         xfer({24'h000000, OFS[b]}, 1'b1, d, r);
         mdl[b] = d[15:0] & MASKS[b];
         xfer({24'h000000, OFS[b]}, 1'b0, 32'h0, r);
         chk_word("readback", {16'h0000, mdl[b]}, r);
      end
      check_all();
      // second reset in mid-run must clear every stored bit
      hresetn <= 1'b0;
      @(posedge hclk);
      #1;
      chk_run("run_in_reset", 16'h0000, run_v[6]);
      foreach (mdl[i]) mdl[i] = 16'h0000;
      @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      check_all();
      summarize();
   end
endmodule : pcg_top_bench
